// >>> rtl/twp_port.sv
// Two-wire serial master port with register access
//
// Overview of operation
// - Frame completion raises enabled done interrupt
// - Busy write to 0x2f01-04 raises illegal interrupt
// - Busy writes to 0x2f01-04 are discarded
// - Clock held low after a frame ending in start, data or restart
// - Config bit 4 selects LSB-first order
// - Config bits pick start, data, stop, restart
// - Clock equals system clock over 4(TH+1)
// - Data register write launches configured frame
// - Register bit order follows the order bit
// - Flag bit 1 reads busy, read-only
// - Receiving master drives flag bit 0 as ack
// - Transmitting master stores sampled ack in bit 0
// - Gate bit 6 enables the port
// - Stop or restart emitted on trigger
// - Data changes on low clock, sampled high
// - Captured byte is the wired-AND line level
// - Start launches the divider counting
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module twp_port
(
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic [15:0]  reg_addr,
  input  wire logic [7:0]   reg_wdata,
  input  wire logic         reg_we,
  input  wire logic         reg_re,
  output var  logic [7:0]   reg_rdata,
  input  wire logic         ext_irq_group_en,
  input  wire logic         global_irq_en,
  input  wire logic         sda_in,
  output var  logic         sda_out,
  output var  logic         sda_oe,
  input  wire logic         scl_in,
  output var  logic         scl_out,
  output var  logic         scl_oe,
  output var  logic         frame_done_irq,
  output var  logic         illegal_write_irq
);
  import twp_pkg::*;

  twp_core_if core ();

  logic [7:0]  peripheral_gate_ctrl;
  logic [7:0]  ext_irq5_enable_reg;
  logic [7:0]  serial_frame_cfg;
  logic [7:0]  scl_divider_low;
  logic [7:0]  scl_divider_high;
  logic [7:0]  serial_data_byte;
  logic [5:0]  flags_rsvd;
  logic        ack_bit;
  logic        busy;
  logic        done_pend;
  twp_state_e  state;
  logic [1:0]  quarter;
  logic [3:0]  slot;
  logic [7:0]  tx_shift;
  logic [7:0]  rx_shift;
  logic [2:0]  sda_sync;
  logic [2:0]  scl_sync;
  logic        sda_f;
  logic        scl_f;
  logic        port_on;
  logic        in_locked;
  logic        wr_ok;
  logic        launch;
  logic        irq_on;
  logic        start_en;
  logic        data_en;
  logic        stop_en;
  logic        restart_en;
  twp_state_e  next_part_start;
  twp_state_e  next_part_data;
  twp_state_e  next_first;

  twp_scl_div u_div
  (
    .clock (clock),
    .rst   (rst),
    .dv    (core)
  );

  twp_bit_order u_ord
  (
    .od (core)
  );

  assign port_on    = peripheral_gate_ctrl[GATE_EN_BIT];
  assign start_en   = serial_frame_cfg[CFG_START_BIT];
  assign data_en    = serial_frame_cfg[CFG_DATA_BIT];
  assign stop_en    = serial_frame_cfg[CFG_STOP_BIT];
  assign restart_en = serial_frame_cfg[CFG_RESTART_BIT];
  assign irq_on     = ext_irq_group_en && global_irq_en;

  // Writes to config, divider and data are locked out while busy
  assign in_locked = (reg_addr >= OFS_CFG) && (reg_addr <= OFS_DATA);
  assign wr_ok     = reg_we && !(busy && in_locked);
  assign launch    = wr_ok && (reg_addr == OFS_DATA) && port_on;

  assign core.run       = busy && (state != TWP_IDLE);
  assign core.threshold = {scl_divider_high, scl_divider_low};
  assign core.lsb_first = serial_frame_cfg[CFG_LSB_BIT];
  // Launch loads the byte being written, not the one it replaces
  assign core.tx_raw    = launch ? reg_wdata : serial_data_byte;
  assign core.rx_ser    = rx_shift;

  // Part ordering inside one frame: start, data, stop or restart
  always_comb
  begin
    next_part_data = TWP_IDLE;
    if (stop_en)
      next_part_data = TWP_STOP;
    else if (restart_en)
      next_part_data = TWP_RESTART;
    next_part_start = data_en ? TWP_DATA : next_part_data;
    next_first      = start_en ? TWP_START : next_part_start;
  end

  // Pin synchronisers, a change counts once two stages agree
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      sda_sync <= SYNC_IDLE;
      scl_sync <= SYNC_IDLE;
    end
    else
    begin
      sda_sync <= {sda_sync[1:0], sda_in};
      scl_sync <= {scl_sync[1:0], scl_in};
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      sda_f <= 1'b1;
      scl_f <= 1'b1;
    end
    else
    begin
      if (sda_sync[2] == sda_sync[1])
        sda_f <= sda_sync[2];
      if (scl_sync[2] == scl_sync[1])
        scl_f <= scl_sync[2];
    end
  end

  // Software registers
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      peripheral_gate_ctrl <= RST_BYTE;
      ext_irq5_enable_reg  <= RST_BYTE;
      serial_frame_cfg     <= RST_BYTE;
      scl_divider_low      <= RST_BYTE;
      scl_divider_high     <= RST_BYTE;
      flags_rsvd           <= RST_RSVD;
    end
    else if (wr_ok)
    begin
      case (reg_addr)
        OFS_GATE:   peripheral_gate_ctrl <= reg_wdata;
        OFS_IRQ_EN: ext_irq5_enable_reg  <= reg_wdata;
        OFS_CFG:    serial_frame_cfg     <= reg_wdata;
        OFS_DIVL:   scl_divider_low      <= reg_wdata;
        OFS_DIVH:   scl_divider_high     <= reg_wdata;
        OFS_FLAGS:  flags_rsvd <= reg_wdata[7:FLG_RSVD_LSB];
        default:    ;
      endcase
    end
  end

  // Data byte: software value, then the captured line byte
  always_ff @(posedge clock)
  begin
    if (rst)
      serial_data_byte <= RST_BYTE;
    else if (wr_ok && (reg_addr == OFS_DATA))
      serial_data_byte <= reg_wdata;
    else if (busy && state == TWP_DATA && core.tick
             && quarter == Q_FALL && slot == ACK_SLOT)
      serial_data_byte <= core.rx_raw;
  end

  // Acknowledge bit: the sampled level wins over a software write
  always_ff @(posedge clock)
  begin
    if (rst)
      ack_bit <= 1'b0;
    else if (busy && state == TWP_DATA && core.tick && scl_f
             && quarter == Q_SAMPLE && slot == ACK_SLOT)
      ack_bit <= sda_f;
    else if (wr_ok && (reg_addr == OFS_FLAGS))
      ack_bit <= reg_wdata[FLG_ACK_BIT];
  end

  // Frame sequencer and open-drain line drivers
  always_ff @(posedge clock)
  begin
    if (rst || !port_on)
    begin
      state     <= TWP_IDLE;
      busy      <= 1'b0;
      done_pend <= 1'b0;
      quarter   <= Q_SET;
      slot      <= SLOT_ZERO;
      tx_shift  <= RST_BYTE;
      rx_shift  <= RST_BYTE;
      sda_oe    <= 1'b0;
      scl_oe    <= 1'b0;
    end
    else if (launch)
    begin
      busy      <= (next_first != TWP_IDLE);
      done_pend <= (next_first == TWP_IDLE);
      state     <= next_first;
      quarter   <= Q_SET;
      slot      <= SLOT_ZERO;
      tx_shift  <= core.tx_ser;
    end
    else if (busy && core.tick)
    begin
      case (state)
        TWP_START, TWP_RESTART:
        begin
          case (quarter)
            Q_SET:    sda_oe <= 1'b0;
            Q_RISE:   scl_oe <= 1'b0;
            Q_SAMPLE: if (scl_f) sda_oe <= 1'b1;
            default:  scl_oe <= 1'b1;
          endcase
          if (quarter != Q_SAMPLE || scl_f)
            quarter <= quarter + 1'b1;
          if (quarter == Q_FALL)
          begin
            state <= (state == TWP_START) ? next_part_start : TWP_IDLE;
            if (state == TWP_RESTART || next_part_start == TWP_IDLE)
            begin
              busy      <= 1'b0;
              done_pend <= 1'b1;
            end
          end
        end
        TWP_DATA:
        begin
          case (quarter)
            Q_SET:    sda_oe <= (slot == ACK_SLOT) ? !ack_bit
                                                   : !tx_shift[7];
            Q_RISE:   scl_oe <= 1'b0;
            Q_SAMPLE: if (scl_f && slot != ACK_SLOT)
                        rx_shift <= {rx_shift[6:0], sda_f};
            default:  scl_oe <= 1'b1;
          endcase
          if (quarter != Q_SAMPLE || scl_f)
            quarter <= quarter + 1'b1;
          if (quarter == Q_FALL)
          begin
            tx_shift <= {tx_shift[6:0], 1'b0};
            slot     <= slot + 1'b1;
            if (slot == ACK_SLOT)
            begin
              slot  <= SLOT_ZERO;
              state <= next_part_data;
              if (next_part_data == TWP_IDLE)
              begin
                busy      <= 1'b0;
                done_pend <= 1'b1;
              end
            end
          end
        end
        TWP_STOP:
        begin
          case (quarter)
            Q_SET:    sda_oe <= 1'b1;
            Q_RISE:   scl_oe <= 1'b0;
            default:  if (scl_f) sda_oe <= 1'b0;
          endcase
          if (quarter == Q_SAMPLE && scl_f)
          begin
            state     <= TWP_IDLE;
            quarter   <= Q_SET;
            busy      <= 1'b0;
            done_pend <= 1'b1;
          end
          else if (quarter != Q_SAMPLE)
            quarter <= quarter + 1'b1;
        end
        default:
        begin
          state <= TWP_IDLE;
          busy  <= 1'b0;
        end
      endcase
    end
  end

  // Pins only pull low or float
  always_ff @(posedge clock)
  begin
    sda_out <= 1'b0;
    scl_out <= 1'b0;
  end

  // Interrupt requests
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      frame_done_irq    <= 1'b0;
      illegal_write_irq <= 1'b0;
    end
    else
    begin
      frame_done_irq <= done_pend && irq_on
                        && ext_irq5_enable_reg[IRQ_DONE_EN_BIT];
      illegal_write_irq <= reg_we && busy && in_locked && irq_on
                           && ext_irq5_enable_reg[IRQ_ILL_EN_BIT];
    end
  end

  // Read data, valid in the cycle after the strobe only
  always_ff @(posedge clock)
  begin
    if (rst || !reg_re)
      reg_rdata <= RST_BYTE;
    else
    begin
      case (reg_addr)
        OFS_GATE:   reg_rdata <= peripheral_gate_ctrl;
        OFS_IRQ_EN: reg_rdata <= ext_irq5_enable_reg;
        OFS_CFG:    reg_rdata <= serial_frame_cfg;
        OFS_DIVL:   reg_rdata <= scl_divider_low;
        OFS_DIVH:   reg_rdata <= scl_divider_high;
        OFS_DATA:   reg_rdata <= serial_data_byte;
        OFS_FLAGS:  reg_rdata <= {flags_rsvd, busy, ack_bit};
        default:    reg_rdata <= RST_BYTE;
      endcase
    end
  end

  // Helper: cycles since the last divider tick
  logic [16:0] gap;
  always_ff @(posedge clock)
  begin
    if (rst || !core.run || core.tick)
      gap <= 17'h1;
    else
      gap <= gap + 17'h1;
  end

  chk_illegal_irq: assert property (@(posedge clock) disable iff (rst)
    reg_we && busy && in_locked && irq_on
    && ext_irq5_enable_reg[IRQ_ILL_EN_BIT] |=> illegal_write_irq)
    else $error("Illegal write did not raise interrupt");

  chk_locked_write: assert property (@(posedge clock) disable iff (rst)
    busy && reg_we && (reg_addr == OFS_DIVL) |=> $stable(scl_divider_low))
    else $error("Busy write changed divider");

  chk_done_irq: assert property (@(posedge clock) disable iff (rst)
    $fell(busy) && irq_on && ext_irq5_enable_reg[IRQ_DONE_EN_BIT]
    |=> frame_done_irq)
    else $error("Completed frame raised no interrupt");

  chk_scl_held: assert property (@(posedge clock) disable iff (rst)
    done_pend && scl_oe && port_on && !launch |=> scl_oe)
    else $error("Clock released while completion pending");

  chk_busy_flag: assert property (@(posedge clock) disable iff (rst)
    launch && next_first != TWP_IDLE |=> busy ##1 (busy || done_pend))
    else $error("Busy flag not set on launch");

  chk_div_period: assert property (@(posedge clock) disable iff (rst)
    core.tick |-> gap == (17'(core.threshold) + 17'h1))
    else $error("Divider tick spacing wrong");

  chk_data_edge: assert property (@(posedge clock) disable iff (rst)
    state == TWP_DATA && $changed(sda_oe) |-> scl_oe)
    else $error("Data line changed while clock high");

  chk_ack_drive: assert property (@(posedge clock) disable iff (rst)
    state == TWP_DATA && slot == ACK_SLOT && quarter == Q_RISE
    |-> sda_oe == !ack_bit)
    else $error("Acknowledge not driven from flag");

  chk_gate_off: assert property (@(posedge clock) disable iff (rst)
    !port_on |=> !sda_oe && !scl_oe && !busy)
    else $error("Disabled port still drives lines");

  chk_frame_start: assert property (@(posedge clock) disable iff (rst)
    launch && start_en |=> state == TWP_START)
    else $error("Start part not entered");

  cov_start: cover property (@(posedge clock) disable iff (rst)
    launch && start_en);
  cov_byte: cover property (@(posedge clock) disable iff (rst)
    state == TWP_DATA && slot == ACK_SLOT && quarter == Q_FALL);
  cov_stop: cover property (@(posedge clock) disable iff (rst)
    state == TWP_STOP ##1 state == TWP_IDLE);
  cov_illegal: cover property (@(posedge clock) disable iff (rst)
    illegal_write_irq);
endmodule
`default_nettype wire

// >>> include/twp_pkg.sv
// Constants and types shared by the two-wire serial master port
`default_nettype none
package twp_pkg;
  // Register offsets
  localparam logic [15:0] OFS_IRQ_EN = 16'h28a5;
  localparam logic [15:0] OFS_GATE   = 16'h2d00;
  localparam logic [15:0] OFS_CFG    = 16'h2f01;
  localparam logic [15:0] OFS_DIVL   = 16'h2f02;
  localparam logic [15:0] OFS_DIVH   = 16'h2f03;
  localparam logic [15:0] OFS_DATA   = 16'h2f04;
  localparam logic [15:0] OFS_FLAGS  = 16'h2f05;
  // Field positions
  localparam int GATE_EN_BIT     = 6;
  localparam int IRQ_DONE_EN_BIT = 4;
  localparam int IRQ_ILL_EN_BIT  = 5;
  localparam int CFG_LSB_BIT     = 4;
  localparam int CFG_START_BIT   = 3;
  localparam int CFG_DATA_BIT    = 2;
  localparam int CFG_STOP_BIT    = 1;
  localparam int CFG_RESTART_BIT = 0;
  localparam int FLG_BUSY_BIT    = 1;
  localparam int FLG_ACK_BIT     = 0;
  localparam int FLG_RSVD_LSB    = 2;
  // Reset values and counts
  localparam logic [7:0] RST_BYTE  = 8'h00;
  localparam logic [5:0] RST_RSVD  = 6'h00;
  localparam logic [2:0] SYNC_IDLE = 3'h7;
  localparam logic [3:0] ACK_SLOT  = 4'h8;
  localparam logic [3:0] SLOT_ZERO = 4'h0;
  // Quarters of one serial clock period
  localparam logic [1:0] Q_SET    = 2'h0;
  localparam logic [1:0] Q_RISE   = 2'h1;
  localparam logic [1:0] Q_SAMPLE = 2'h2;
  localparam logic [1:0] Q_FALL   = 2'h3;
  typedef enum logic [2:0]
  {
    TWP_IDLE,
    TWP_START,
    TWP_DATA,
    TWP_STOP,
    TWP_RESTART
  } twp_state_e;
endpackage
`default_nettype wire

// >>> include/twp_core_if.sv
// Signals between the port core, its divider and its bit orderer
`timescale 1ns/1ns
`default_nettype none
interface twp_core_if;
  logic        run;
  logic [15:0] threshold;
  logic        tick;
  logic        lsb_first;
  logic [7:0]  tx_raw;
  logic [7:0]  tx_ser;
  logic [7:0]  rx_ser;
  logic [7:0]  rx_raw;
  modport core (output run, threshold, lsb_first, tx_raw, rx_ser,
                input tick, tx_ser, rx_raw);
  modport div (input run, threshold, output tick);
  modport ord (input lsb_first, tx_raw, rx_ser, output tx_ser, rx_raw);
endinterface
`default_nettype wire

// >>> rtl/twp_scl_div.sv
// Quarter-period tick generator for the serial clock
`timescale 1ns/1ns
`default_nettype none
module twp_scl_div
#(
  parameter int W = 16
)
(
  input wire logic clock,
  input wire logic rst,
  twp_core_if.div  dv
);
  logic [W-1:0] count;

  if (W != $bits(dv.threshold))
  begin : g_chk
    $error("Divider width must match the threshold width");
  end

  // One tick every threshold+1 clocks while running
  assign dv.tick = dv.run && (count == dv.threshold);

  always_ff @(posedge clock)
  begin
    if (rst || !dv.run || dv.tick)
      count <= '0;
    else
      count <= count + 1'b1;
  end
endmodule
`default_nettype wire

// >>> rtl/twp_bit_order.sv
// Byte reversal between register order and serial order
`timescale 1ns/1ns
`default_nettype none
module twp_bit_order
#(
  parameter int W = 8
)
(
  twp_core_if.ord od
);
  if (W != $bits(od.tx_raw))
  begin : g_chk
    $error("Orderer width must match the data width");
  end

  // Serial side is always shifted from the top bit
  for (genvar i = 0; i < W; i++)
  begin : g_bit
    assign od.tx_ser[i] = od.lsb_first ? od.tx_raw[W-1-i] : od.tx_raw[i];
    assign od.rx_raw[i] = od.lsb_first ? od.rx_ser[W-1-i] : od.rx_ser[i];
  end
endmodule
`default_nettype wire

// >>> test/twp_slave_model.sv
// Behavioural two-wire slave that answers its address and can stretch
`timescale 1ns/1ns
`default_nettype none
module twp_slave_model
#(
  parameter logic [6:0] ADDR  = 7'h2a,
  parameter logic [7:0] RBYTE = 8'h96
)
(
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       stretch,
  output var  logic       sda_low,
  output var  logic       scl_low,
  output var  logic [7:0] got,
  output var  logic       mnack
);
  logic [7:0] sh;
  int         bitn;
  logic       act, first, sel, rd, tx;
  initial
  begin
    {sda_low, scl_low, act, tx, mnack} = '0;
    got = 8'h00;
  end
  // Start or restart seen on the wire
  always @(negedge sda)
    if (scl === 1'b1)
    begin
      {act, first, sel, tx} = 4'b1100;
      bitn = 0;
    end
  // Stop seen on the wire
  always @(posedge sda)
    if (scl === 1'b1)
      act = 1'b0;
  // Sample on rising clock
  always @(posedge scl)
    if (act)
    begin
      if (bitn < 8)
        sh = {sh[6:0], sda};
      else
        mnack = sda;
      bitn = bitn + 1;
    end
  // Change on falling clock
  always @(negedge scl)
    if (act)
    begin
      sda_low = 1'b0;
      if (bitn == 8)
      begin
        if (first)
          {sel, rd} = {sh[7:1] == ADDR, sh[0]};
        else if (!rd)
          got = sh;
        tx = 1'b0;
        sda_low = sel && (first || !rd);
      end
      else if (bitn == 9)
      begin
        tx = sel && rd && (first || !mnack);
        first = 1'b0;
        bitn = 0;
      end
      if (tx)
        sda_low = !RBYTE[7 - bitn];
      if (stretch && bitn == 4)
      begin
        scl_low = 1'b1;
        #120;
        scl_low = 1'b0;
      end
    end
endmodule
`default_nettype wire

// >>> test/tb.sv
// Self-checking bench for the two-wire serial master port
`timescale 1ns/1ns
`default_nettype none
module tb;
  import twp_pkg::*;
  // A quarter must outlast the clock pin synchroniser: TH of 4 or more
  localparam int         TH = 4;
  localparam logic [6:0] SA = 7'h2a;
  localparam logic [7:0] RB = 8'h96;
  logic        clock, rst, reg_we, reg_re, stretch;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, rv, got;
  logic        ext_irq_group_en, global_irq_en;
  logic        sda_out, sda_oe, scl_out, scl_oe, mnack;
  logic        frame_done_irq, illegal_write_irq, sda_low, scl_low;
  logic [31:0] t_last, t_per;
  int          fail_count, n_checks;
  logic [15:0] regs [6] = '{OFS_GATE, OFS_CFG, OFS_DIVL, OFS_DIVH,
                            OFS_FLAGS, 16'h2f07};
  wire         sda_w = !(sda_oe || sda_low);
  wire         scl_w = !(scl_oe || scl_low);

  twp_port u_dut (.clock(clock), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .ext_irq_group_en(ext_irq_group_en),
    .global_irq_en(global_irq_en), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe(sda_oe), .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe),
    .frame_done_irq(frame_done_irq),
    .illegal_write_irq(illegal_write_irq));
  twp_slave_model #(.ADDR(SA), .RBYTE(RB)) u_slave (.scl(scl_w),
    .sda(sda_w), .stretch(stretch), .sda_low(sda_low),
    .scl_low(scl_low), .got(got), .mnack(mnack));

  always #4 clock = !clock;
  // Serial clock period from one low pull to the next
  always @(posedge scl_oe)
  begin
    t_per = 32'($time) - t_last;
    t_last = 32'($time);
  end

  task automatic close_out();
    $display("checks=%0d errors=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_we    <= 1'b1;
    @(posedge clock);
    reg_we    <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_re   <= 1'b1;
    @(posedge clock);
    reg_re   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic rchk(input logic [15:0] a, input logic [7:0] e);
    rd(a, rv);
    chk(rv, e);
  endtask
  task automatic launch(input logic [7:0] c, f, d);
    wr(OFS_CFG, c);
    wr(OFS_FLAGS, f);
    wr(OFS_DATA, d);
    rd(OFS_FLAGS, rv);
    chk(rv[FLG_BUSY_BIT], 1);
  endtask
  task automatic idle();
    int i;
    for (i = 0; i < 3000 && rv[FLG_BUSY_BIT] !== 1'b0; i++)
      rd(OFS_FLAGS, rv);
    if (i == 3000)
    begin
      fail_count++;
      close_out();
    end
  endtask
  task automatic run(input logic [7:0] c, f, d);
    launch(c, f, d);
    idle();
  endtask

  initial
  begin
    {clock, rst, reg_we, reg_re, stretch} = 5'b01000;
    {reg_addr, reg_wdata} = '0;
    {ext_irq_group_en, global_irq_en} = 2'b11;
    {fail_count, n_checks} = '0;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    foreach (regs[k])
      rchk(regs[k], 8'h00);
    wr(OFS_FLAGS, 8'hff);
    rchk(OFS_FLAGS, 8'hfd);
    wr(OFS_FLAGS, 8'h00);
    wr(OFS_CFG, 8'h08);
    wr(OFS_DATA, 8'h00);
    rchk(OFS_FLAGS, 8'h00);
    wr(OFS_IRQ_EN, 8'h30);
    wr(OFS_DIVL, 8'(TH));
    wr(OFS_DIVH, 8'h00);
    rchk(OFS_DIVL, 8'(TH));
    wr(OFS_GATE, 8'h40);
    // Unanswered address, then stop
    run(8'h08, 8'h00, 8'h00);
    repeat (40) @(posedge clock);
    #1;
    chk({scl_oe, scl_w}, 2'b10);
    chk(frame_done_irq, 1);
    global_irq_en <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
    chk(frame_done_irq, 0);
    global_irq_en <= 1'b1;
    run(8'h04, 8'h01, {7'h11, 1'b0});
    rchk(OFS_FLAGS, 8'h01);
    run(8'h02, 8'h00, 8'h00);
    chk({scl_w, sda_w, sda_out, scl_out}, 4'b1100);
    // Write transaction, MSB then LSB first
    run(8'h08, 8'h00, 8'h00);
    run(8'h04, 8'h01, {SA, 1'b0});
    rchk(OFS_FLAGS, 8'h00);
    rchk(OFS_DATA, {SA, 1'b0});
    chk(t_per, 32 * (TH + 1));
    stretch = 1'b1;
    run(8'h04, 8'h01, 8'ha5);
    stretch = 1'b0;
    chk(got, 8'ha5);
    launch(8'h14, 8'h01, 8'h35);
    wr(OFS_CFG, 8'h1f);
    #1;
    chk(illegal_write_irq, 1);
    wr(OFS_DIVL, 8'h00);
    idle();
    rchk(OFS_CFG, 8'h14);
    rchk(OFS_DIVL, 8'(TH));
    chk(got, 8'hac);
    rchk(OFS_DATA, 8'h35);
    // Restart and read two bytes
    run(8'h01, 8'h00, 8'h00);
    run(8'h04, 8'h01, {SA, 1'b1});
    rchk(OFS_FLAGS, 8'h00);
    run(8'h04, 8'h00, 8'hff);
    chk(mnack, 0);
    rchk(OFS_DATA, RB);
    run(8'h04, 8'h01, 8'hff);
    chk(mnack, 1);
    rchk(OFS_FLAGS, 8'h01);
    rchk(OFS_DATA, RB);
    run(8'h02, 8'h00, 8'h00);
    chk({scl_oe, sda_oe}, 2'b00);
    close_out();
  end
endmodule
`default_nettype wire
